// [include/ssi_pkg.sv]
`default_nettype none
package ssi_pkg;
  // Register byte offsets on the AHB-Lite slave.
  localparam int                ADDR_W      = 8;
  localparam logic [ADDR_W-1:0] ADDR_MODE   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_BUS    = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_BAUD   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_TXBUF  = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_RXBUF  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;

  // Mode register layout.
  localparam int MODE_W        = 15;
  localparam int MODE_FIELD_W  = 3;
  localparam int F_MODE_LO     = 0;
  localparam int F_TWO_WIRE    = 3;
  localparam int F_IRQ_STYLE   = 4;
  localparam int F_CLK_SRC     = 5;
  localparam int F_POLARITY    = 6;
  localparam int F_PHASE       = 7;
  localparam int F_TX_IRQ_SRC  = 8;
  localparam int F_DLY_LO      = 9;
  localparam int DLY_W         = 3;
  localparam int F_TX_ALLOW    = 12;
  localparam int F_RX_ALLOW    = 13;
  localparam int F_SDA_INIT    = 14;

  // Bus control register layout.
  localparam int BUS_W         = 10;
  localparam int F_SYNC        = 0;
  localparam int F_HOLD9       = 1;
  localparam int F_FORCE_LOW   = 2;
  localparam int F_HOLD10      = 3;
  localparam int F_REL_STOP    = 4;
  localparam int F_SDA_DIS     = 5;
  localparam int F_COND_SEL    = 6;
  localparam int F_ACK_EN      = 7;
  localparam int F_ACK_VAL     = 8;
  localparam int F_RESYNC      = 9;

  // Data and status layout.
  localparam int BUF_W         = 9;
  localparam int RX_OVR_BIT    = 11;
  localparam int STAT_W        = 5;

  // Reset values.
  localparam logic [MODE_W-1:0] MODE_RESET = 15'h0000;
  localparam logic [BUS_W-1:0]  BUS_RESET  = 10'h000;

  // Serial mode field codes.
  localparam logic [MODE_FIELD_W-1:0] MODE_OFF      = 3'h0;
  localparam logic [MODE_FIELD_W-1:0] MODE_SYNC     = 3'h1;
  localparam logic [MODE_FIELD_W-1:0] MODE_TWO_WIRE = 3'h2;

  // Bit counts.
  localparam logic [3:0] BITS_I2C    = 4'h9;
  localparam logic [3:0] BITS_SYNC   = 4'h8;
  localparam logic [3:0] BIT_ACK_POS = 4'h8;
  localparam logic [3:0] BIT_EIGHTH  = 4'h7;
  localparam logic [3:0] BIT_SEVENTH = 4'h6;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } ssi_state_t;
endpackage
`default_nettype wire

// [rtl/ssi_baud_gen.sv]
`timescale 1ns/1ps
`default_nettype none
// Divider that ticks once every div+1 count-source cycles while running.
module ssi_baud_gen #(
  parameter int DIV_W = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic             reload,
  input  wire logic             pause,
  input  wire logic [DIV_W-1:0] div,
  output logic                  tick
);
  logic [DIV_W-1:0] count;

  assign tick = run & !pause & !reload & (count == '0);

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else if (!run | reload | tick) begin
      count <= div;
    end else if (!pause) begin
      count <= count - {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// [rtl/ssi_serial_core.sv]
`timescale 1ns/1ps
`default_nettype none
module ssi_serial_core #(
  parameter int DIV_W = 8
) (
  input  wire logic                      CLK_SYS,
  input  wire logic                      RST,
  input  wire logic                      HSEL,
  input  wire logic [31:0]               HADDR,
  input  wire logic [1:0]                HTRANS,
  input  wire logic                      HWRITE,
  input  wire logic [2:0]                HSIZE,
  input  wire logic [31:0]               HWDATA,
  input  wire logic                      HREADY,
  output logic                           HREADYOUT,
  output logic                           HRESP,
  output logic [31:0]                    HRDATA,
  input  wire logic                      SCL_IN,
  output logic                           SCL_OUT,
  output logic                           SCL_OE,
  input  wire logic                      SDA_IN,
  output logic                           SDA_OUT,
  output logic                           SDA_OE,
  input  wire logic                      SCK_IN,
  output logic                           SCK_OUT,
  output logic                           SCK_OE,
  output logic                           TXD,
  input  wire logic                      RXD,
  output logic                           TX_IRQ,
  output logic                           RX_IRQ,
  output logic                           ACK_IRQ,
  output logic                           NACK_IRQ,
  output logic                           START_DET,
  output logic                           STOP_DET
);
  import ssi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and fields.
  logic [MODE_W-1:0] mode_reg;
  logic [BUS_W-1:0]  bus_reg;
  logic [DIV_W-1:0]  baud_divider;
  logic [BUF_W-1:0]  tx_buffer;
  logic [BUF_W-1:0]  rx_buffer;
  logic              tx_buffer_empty_flag;
  logic              rx_complete_flag;
  logic              overrun_flag;
  logic              sda_init;
  logic              hold_low;

  wire logic [MODE_FIELD_W-1:0] serial_mode_field = mode_reg[F_MODE_LO +: MODE_FIELD_W];
  wire logic             two_wire_mode_select  = mode_reg[F_TWO_WIRE];
  wire logic             i2c_irq_style         = mode_reg[F_IRQ_STYLE];
  wire logic             clock_source_select   = mode_reg[F_CLK_SRC];
  wire logic             clock_polarity        = mode_reg[F_POLARITY];
  wire logic             clock_phase_delay     = mode_reg[F_PHASE];
  wire logic             tx_irq_source         = mode_reg[F_TX_IRQ_SRC];
  wire logic [DLY_W-1:0] sda_delay_select      = mode_reg[F_DLY_LO +: DLY_W];
  wire logic             tx_allow              = mode_reg[F_TX_ALLOW];
  wire logic             rx_allow              = mode_reg[F_RX_ALLOW];
  wire logic             clock_sync_enable     = bus_reg[F_SYNC];
  wire logic             ninth_clock_scl_hold  = bus_reg[F_HOLD9];
  wire logic             scl_force_low         = bus_reg[F_FORCE_LOW];
  wire logic             post_ninth_scl_hold   = bus_reg[F_HOLD10];
  wire logic             clock_release_on_stop = bus_reg[F_REL_STOP];
  wire logic             data_output_disable   = bus_reg[F_SDA_DIS];
  wire logic             condition_output_select = bus_reg[F_COND_SEL];
  wire logic             ack_output_enable     = bus_reg[F_ACK_EN];
  wire logic             ack_value             = bus_reg[F_ACK_VAL];
  wire logic             start_resync_enable   = bus_reg[F_RESYNC];

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY.
  logic              wr_pend;
  logic [ADDR_W-1:0] wr_addr;

  wire logic accept = HSEL & HTRANS[1] & HREADY;
  wire logic rd_rx  = accept & !HWRITE & (HADDR[ADDR_W-1:0] == ADDR_RXBUF);
  wire logic wr_mode = wr_pend & (wr_addr == ADDR_MODE);
  wire logic wr_bus  = wr_pend & (wr_addr == ADDR_BUS);
  wire logic wr_baud = wr_pend & (wr_addr == ADDR_BAUD);
  wire logic wr_tx   = wr_pend & (wr_addr == ADDR_TXBUF);

  assign HREADYOUT = 1'h1;
  assign HRESP     = 1'h0;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wr_pend <= 1'h0;
      wr_addr <= '0;
    end else begin
      wr_pend <= accept & HWRITE;
      if (accept) begin
        wr_addr <= HADDR[ADDR_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode, pins and edges.
  ssi_state_t       st;
  logic [3:0]       cnt;
  logic [BUF_W-1:0] tx_shift;
  logic [7:0]       rx_shift;
  logic             tx_out;
  logic             int_scl;
  logic             clk_q;
  logic             scl_q;
  logic             sda_q;
  logic             tick;
  logic [7:0]       dly_line;

  wire logic i2c      = two_wire_mode_select & (serial_mode_field == MODE_TWO_WIRE);
  wire logic sync     = serial_mode_field == MODE_SYNC;
  wire logic internal = !clock_source_select;
  wire logic busy     = st == ST_SHIFT;
  wire logic rx_pin   = i2c ? SDA_IN : RXD;

  wire logic start_det = scl_q & SCL_IN & sda_q & !SDA_IN;
  wire logic stop_det  = scl_q & SCL_IN & !sda_q & SDA_IN;
  wire logic scl_fell  = scl_q & !SCL_IN;
  wire logic resync    = i2c & start_det & start_resync_enable;

  // Slave byte mode relies on the remote clock resting at its idle level.
  wire logic slave_clk = SCK_IN ^ clock_polarity;
  wire logic line_clk  = i2c ? (int_scl & SCL_IN) :
                         sync ? (internal ? int_scl : slave_clk) : 1'h1;
  wire logic rise      = line_clk & !clk_q;
  wire logic fall      = !line_clk & clk_q;
  wire logic swap      = sync & clock_phase_delay;
  wire logic sample_e  = busy & (swap ? fall : rise);
  wire logic launch_e  = busy & (swap ? rise : fall);

  wire logic [3:0] end_cnt = BITS_I2C + {3'h0, clock_phase_delay & post_ninth_scl_hold};
  wire logic i2c_done  = i2c & busy & fall & (cnt == end_cnt);
  wire logic sync_done = sync & sample_e & (cnt == BITS_SYNC - 4'h1);
  wire logic load      = !busy & (i2c | sync) & tx_allow & !tx_buffer_empty_flag & !wr_tx;

  wire logic store_ack  = i2c & !i2c_irq_style & sample_e & (cnt == BIT_ACK_POS);
  wire logic store_xfer = i2c & i2c_irq_style & sample_e & (cnt == BIT_EIGHTH);
  wire logic store_sync = sync_done & rx_allow;
  wire logic rx_store   = store_ack | store_xfer | store_sync;
  wire logic rx_track   = i2c | rx_allow;
  wire logic overrun_e  = rx_track & sample_e & (cnt == BIT_SEVENTH) & rx_complete_flag;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      clk_q <= 1'h1;
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      clk_q <= line_clk;
      scl_q <= SCL_IN;
      sda_q <= SDA_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      mode_reg     <= MODE_RESET;
      baud_divider <= '0;
      sda_init     <= 1'h1;
    end else begin
      if (wr_mode) begin
        mode_reg <= HWDATA[MODE_W-1:0];
        if (HWDATA[F_TWO_WIRE] &&
            HWDATA[F_MODE_LO +: MODE_FIELD_W] == MODE_OFF) begin
          sda_init <= HWDATA[F_SDA_INIT];
        end
      end
      if (wr_baud) begin
        baud_divider <= HWDATA[DIV_W-1:0];
      end
    end
  end

  // Hardware setting of the ninth hold overrides a same-cycle software write.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      bus_reg <= BUS_RESET;
    end else begin
      if (wr_bus) begin
        bus_reg <= HWDATA[BUS_W-1:0];
      end
      if (resync) begin
        bus_reg[F_HOLD9] <= 1'h1;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      tx_buffer            <= '0;
      tx_buffer_empty_flag <= 1'h1;
    end else begin
      if (wr_tx) begin
        tx_buffer            <= HWDATA[BUF_W-1:0];
        tx_buffer_empty_flag <= 1'h0;
      end
      if (load) begin
        tx_buffer_empty_flag <= 1'h1;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      HRDATA <= '0;
    end else if (accept & !HWRITE) begin
      unique case (HADDR[ADDR_W-1:0])
        ADDR_MODE:   HRDATA <= {17'h0, mode_reg};
        ADDR_BUS:    HRDATA <= {22'h0, bus_reg};
        ADDR_BAUD:   HRDATA <= {{(32-DIV_W){1'b0}}, baud_divider};
        ADDR_RXBUF:  HRDATA <= {20'h0, overrun_flag, 2'h0, rx_buffer};
        ADDR_STATUS: HRDATA <= {27'h0, hold_low, busy, overrun_flag,
                                rx_complete_flag, tx_buffer_empty_flag};
        default:     HRDATA <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal clock generation.
  wire logic sync_pull = i2c & clock_sync_enable & scl_fell & int_scl;
  wire logic run_gen   = busy & internal;

  ssi_baud_gen #(
    .DIV_W (DIV_W)
  ) u_baud (
    .clk    (CLK_SYS),
    .rst    (RST),
    .run    (run_gen),
    .reload (sync_pull),
    .pause  (i2c & clock_sync_enable & int_scl & !SCL_IN),
    .div    (baud_divider),
    .tick   (tick)
  );

  // The clock rests high, so the first edge after a load comes one half period later.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      int_scl <= 1'h1;
    end else if (!run_gen) begin
      int_scl <= 1'h1;
    end else if (sync_pull) begin
      int_scl <= 1'h0;
    end else if (tick) begin
      int_scl <= !int_scl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shifter: D7 first; D8 last in two-wire mode unless the ack value replaces it, D0 last in sync mode.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st       <= ST_IDLE;
      cnt      <= '0;
      tx_shift <= '0;
      rx_shift <= '0;
      tx_out   <= 1'h1;
    end else if (resync) begin
      st       <= ST_SHIFT;
      cnt      <= '0;
      tx_shift <= {tx_buffer[7:0], tx_buffer[8]};
      rx_shift <= '0;
    end else if (!(i2c | sync)) begin
      st <= ST_IDLE;
      if (serial_mode_field == MODE_OFF) begin
        tx_out <= sda_init;
      end
    end else begin
      unique case (st)
        ST_IDLE: begin
          if (load) begin
            st       <= ST_SHIFT;
            cnt      <= '0;
            rx_shift <= '0;
            tx_shift <= {tx_buffer[7:0], tx_buffer[8]};
            if (swap) begin
              tx_out   <= tx_buffer[7];
              tx_shift <= {tx_buffer[6:0], tx_buffer[8], 1'h0};
            end
          end
        end
        ST_SHIFT: begin
          if (sample_e) begin
            cnt      <= cnt + 4'h1;
            rx_shift <= {rx_shift[6:0], rx_pin};
          end
          if (launch_e) begin
            tx_shift <= {tx_shift[BUF_W-2:0], 1'h0};
            // The closing clock fall releases the data line, so no tenth bit goes out.
            if (i2c && cnt == BIT_ACK_POS && !condition_output_select && ack_output_enable) begin
              tx_out <= ack_value;
            end else if (i2c && cnt >= BITS_I2C) begin
              tx_out <= 1'h1;
            end else begin
              tx_out <= tx_shift[BUF_W-1];
            end
          end
          if (i2c_done | sync_done) begin
            st <= ST_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer and flags; a hardware set wins over a read clear.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rx_buffer        <= '0;
      rx_complete_flag <= 1'h0;
      overrun_flag     <= 1'h0;
    end else begin
      if (rd_rx) begin
        rx_complete_flag <= 1'h0;
        overrun_flag     <= 1'h0;
      end
      if (store_ack) begin
        rx_buffer <= {SDA_IN, rx_shift};
      end else if (store_xfer) begin
        rx_buffer <= {SDA_IN, 1'h0, rx_shift[6:0]};
      end else if (store_sync) begin
        rx_buffer <= {1'h0, rx_shift[6:0], RXD};
      end
      if (rx_store) begin
        rx_complete_flag <= 1'h1;
      end
      if (overrun_e) begin
        overrun_flag <= 1'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events.
  wire logic tx_done = tx_irq_source & (sync_done | (i2c & sample_e & (cnt == BIT_ACK_POS)));

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      TX_IRQ    <= 1'h0;
      RX_IRQ    <= 1'h0;
      ACK_IRQ   <= 1'h0;
      NACK_IRQ  <= 1'h0;
      START_DET <= 1'h0;
      STOP_DET  <= 1'h0;
    end else begin
      TX_IRQ    <= (load & !tx_irq_source) | tx_done;
      RX_IRQ    <= rx_store & !overrun_flag;
      ACK_IRQ   <= store_ack & !SDA_IN;
      NACK_IRQ  <= store_ack & SDA_IN;
      START_DET <= i2c & start_det;
      STOP_DET  <= i2c & stop_det;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus clock hold and pin drive.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      hold_low <= 1'h0;
    end else if (i2c & stop_det & clock_release_on_stop) begin
      hold_low <= 1'h0;
    end else if (!ninth_clock_scl_hold & !post_ninth_scl_hold) begin
      hold_low <= 1'h0;
    end else if (i2c & busy & fall) begin
      if (cnt == BITS_I2C && ninth_clock_scl_hold) begin
        hold_low <= 1'h1;
      end
      if (cnt == BITS_I2C + 4'h1 && clock_phase_delay && post_ninth_scl_hold) begin
        hold_low <= 1'h1;
      end
    end
  end

  // Data output delay measured in count-source cycles.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      dly_line <= 8'hff;
    end else begin
      dly_line <= {dly_line[6:0], tx_out};
    end
  end

  wire logic sda_dly = (sda_delay_select == '0) ? tx_out : dly_line[sda_delay_select];

  assign SCL_OUT = 1'h0;
  assign SDA_OUT = 1'h0;
  assign SCL_OE  = i2c & (scl_force_low | hold_low | (internal & !int_scl));
  assign SDA_OE  = i2c & !data_output_disable & !sda_dly;
  assign SCK_OE  = sync & internal;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      SCK_OUT <= 1'h1;
      TXD     <= 1'h1;
    end else begin
      SCK_OUT <= int_scl ^ clock_polarity;
      TXD     <= sync ? tx_out : 1'h1;
    end
  end
endmodule
`default_nettype wire

// [verif/ssi_core_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module ssi_core_asserts
  import ssi_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic [31:0] HRDATA,
  input wire logic        SCL_IN,
  input wire logic        SCL_OUT,
  input wire logic        SCL_OE,
  input wire logic        SDA_IN,
  input wire logic        SDA_OUT,
  input wire logic        SDA_OE,
  input wire logic        SCK_OUT,
  input wire logic        TXD,
  input wire logic        TX_IRQ,
  input wire logic        RX_IRQ,
  input wire logic        ACK_IRQ,
  input wire logic        NACK_IRQ,
  input wire logic        START_DET,
  input wire logic        STOP_DET
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  wire rd_req = HSEL && HTRANS[1] && HREADY && !HWRITE;

  AST_OKAY_ZERO_WAIT: assert property (HREADYOUT && !HRESP)
    else $error("bus answer is not zero-wait okay");
  AST_OPEN_DRAIN: assert property (!SCL_OUT && !SDA_OUT)
    else $error("open-drain pin drives high");
  AST_RESET_IDLE: assert property ($fell(RST) |-> !SCL_OE && !SDA_OE && TXD && SCK_OUT)
    else $error("pins not idle after reset");
  AST_UNMAPPED_READ: assert property (rd_req && HADDR[7:0] == 8'h18 |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  AST_RDATA_HOLD: assert property (!rd_req |=> $stable(HRDATA))
    else $error("read data moved without a read");
  AST_ACK_CAUSE: assert property (ACK_IRQ |-> $past(SCL_IN) && !$past(SDA_IN))
    else $error("ack event without low data at clock high");
  AST_NACK_CAUSE: assert property (NACK_IRQ |-> $past(SCL_IN) && $past(SDA_IN) && !ACK_IRQ)
    else $error("nack event without high data at clock high");
  AST_START_CAUSE: assert property (START_DET |-> $past(SCL_IN) && !$past(SDA_IN) && !STOP_DET)
    else $error("start seen without data low under clock high");
  AST_STOP_CAUSE: assert property (STOP_DET |-> $past(SCL_IN) && $past(SDA_IN))
    else $error("stop seen without data high under clock high");
  AST_TX_PULSE: assert property (TX_IRQ |=> !TX_IRQ)
    else $error("transmit event longer than one cycle");
  AST_RX_PULSE: assert property (RX_IRQ |=> !RX_IRQ)
    else $error("receive event longer than one cycle");

  cover property (ACK_IRQ);
  cover property (NACK_IRQ);
  cover property (START_DET ##[1:40] STOP_DET);
  cover property (RX_IRQ);
endmodule
bind ssi_serial_core ssi_core_asserts #(.DIV_W(DIV_W)) ssi_core_asserts_i (.*);
`default_nettype wire

// [verif/ssi_bus_peer.sv]
`timescale 1ns/1ps
`default_nettype none
// Bus slave on the two-wire lines: captures bytes, acknowledges, may stretch the clock.
module ssi_bus_peer (
  input  wire logic       clk,
  input  wire logic       scl_dev_low,
  input  wire logic       sda_dev_low,
  input  wire logic       nack,
  input  wire logic       slow,
  input  wire logic       hold_sda_low,
  output logic            scl,
  output logic            sda,
  output logic [7:0]      got
);
  logic       scl_q   = 1'b1;
  logic       sda_q   = 1'b1;
  logic       ack_low = 1'b0;
  logic [3:0] cnt     = 4'h0;
  logic [2:0] str     = 3'h0;
  // Both lines have pull-ups, so a released line reads high.
  assign scl = !(scl_dev_low || str != 3'h0);
  assign sda = !(sda_dev_low || ack_low || hold_sda_low);
  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl_q && !scl && slow)
      str <= 3'h7;
    else if (str != 3'h0)
      str <= str - 3'h1;
    if (scl_q && sda_q && !sda) begin
      cnt <= 4'h0;
    end else if (!scl_q && scl) begin
      if (cnt < 4'h8)
        got <= {got[6:0], sda};
      cnt <= (cnt == 4'hf) ? 4'h0 : cnt + 4'h1;
    end else if (scl_q && !scl) begin
      ack_low <= (cnt == 4'h8) && !nack;
      // The clock returns high once after each byte; that pulse carries no bit.
      if (cnt == 4'h9)
        cnt <= 4'hf;
    end
  end
endmodule
`default_nettype wire

// [verif/ssi_serial_core_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module ssi_serial_core_bench;
  import ssi_pkg::*;
  logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, nack = 0, slow = 0, cond = 0, sck_in = 1;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, m;
  logic [7:0]  b;
  wire logic [31:0] hrdata;
  wire logic [7:0]  got;
  wire logic ready, resp, scl, sda, scl_o, sda_o, scl_oe, sda_oe, sck, sck_oe, txd;
  wire logic tx_irq, rx_irq, ack, nak, st, sp;
  int n_fail = 0, comparisons = 0, cyc = 0, seed = 27, k, t, a, q;
  int n_tx = 0, n_rx = 0, n_ack = 0, n_nack = 0, n_st = 0, n_sp = 0;

  always #12.5 clk = ~clk;

  ssi_serial_core #(.DIV_W(8)) ssi_serial_core_i (
    .CLK_SYS(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(ready),
    .HREADYOUT(ready), .HRESP(resp), .HRDATA(hrdata), .SCL_IN(scl), .SCL_OUT(scl_o),
    .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE(sda_oe), .SCK_IN(sck_in),
    .SCK_OUT(sck), .SCK_OE(sck_oe), .TXD(txd), .RXD(txd), .TX_IRQ(tx_irq),
    .RX_IRQ(rx_irq), .ACK_IRQ(ack), .NACK_IRQ(nak), .START_DET(st), .STOP_DET(sp));

  ssi_bus_peer ssi_bus_peer_i (
    .clk(clk), .scl_dev_low(scl_oe), .sda_dev_low(sda_oe), .nack(nack), .slow(slow),
    .hold_sda_low(cond), .scl(scl), .sda(sda), .got(got));

  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_tx <= n_tx + tx_irq;
    n_rx <= n_rx + rx_irq;
    n_ack <= n_ack + ack;
    n_nack <= n_nack + nak;
    n_st <= n_st + st;
    n_sp <= n_sp + sp;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      test_done;
    end
  end

  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    @(posedge clk);
    while (ready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= d;
    @(posedge clk);
    while (ready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wait_done;
    do bus(0, ADDR_STATUS, 0); while (!rd[3]);
    do bus(0, ADDR_STATUS, 0); while (rd[3]);
  endtask

  function automatic logic [8:0] exp_rx(input logic sty, input logic [7:0] v);
    return sty ? {v[0], 1'b0, v[7:1]} : {1'b0, v};
  endfunction

  task test_done;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    bus(0, ADDR_STATUS, 0); chk("status", rd, 32'h1);
    bus(0, ADDR_MODE, 0); chk("mode", rd, {17'h0, MODE_RESET});
    bus(0, ADDR_BUS, 0); chk("buscfg", rd, {22'h0, BUS_RESET});
    bus(0, 8'h18, 0); chk("unmapped", rd, 32'h0);
    b = $random(seed);
    bus(1, ADDR_BAUD, {24'h0, b}); bus(0, ADDR_BAUD, 0); chk("baud", rd, {24'h0, b});
    bus(1, ADDR_BAUD, 32'h3);
    for (int p = 0; p < 4; p++) begin
      b = (p == 0) ? 8'h01 : 8'($random(seed));
      m = 32'h1 | (p << 6) | ((p >> 1) << 8);
      k = n_rx;
      t = n_tx;
      bus(1, ADDR_MODE, m);
      bus(1, ADDR_TXBUF, {24'h0, b});
      repeat (40) @(posedge clk);
      chk("held", n_rx, k);
      bus(1, ADDR_MODE, m | 32'h3000);
      while (n_rx == k) @(posedge clk);
      bus(0, ADDR_RXBUF, 0); chk("rxbyte", rd[7:0], b);
      chk("txirq", n_tx, t + 1);
    end
    k = n_rx;
    bus(1, ADDR_TXBUF, 32'h5a);
    while (n_rx == k) @(posedge clk);
    bus(1, ADDR_TXBUF, 32'ha5);
    wait_done;
    bus(0, ADDR_RXBUF, 0); chk("overrun", rd[11], 1);
    chk("ovr_irq", n_rx, k + 1);
    bus(0, ADDR_STATUS, 0); chk("ovr_clear", rd[2], 0);
    b = 8'($random(seed)) | 8'h01;
    bus(1, ADDR_MODE, 32'h0021);
    bus(1, ADDR_TXBUF, {24'h0, b});
    bus(1, ADDR_MODE, 32'h3021);
    repeat (16) begin
      repeat (4) @(posedge clk);
      sck_in <= !sck_in;
    end
    repeat (4) @(posedge clk);
    chk("sck_oe", sck_oe, 0);
    bus(0, ADDR_RXBUF, 0); chk("slave", rd[7:0], b);
    bus(1, ADDR_MODE, 32'h300a);
    cond <= 1;
    repeat (10) @(posedge clk);
    cond <= 0;
    repeat (10) @(posedge clk);
    chk("conds", {n_st[15:0], n_sp[15:0]}, 32'h00010001);
    for (int i = 0; i < 3; i++) begin
      nack <= (i == 1);
      slow <= (i == 1);
      b = $random(seed);
      a = n_ack;
      q = n_nack;
      m = (i == 2) ? 32'h17f : 32'h0ff;
      bus(1, ADDR_BUS, {31'h0, i == 1});
      bus(1, ADDR_MODE, 32'h300a | ((i == 2) << 4) | ((i == 0) << 9));
      bus(1, ADDR_TXBUF, {23'h0, 1'b1, b});
      wait_done;
      chk("peer", got, b);
      bus(0, ADDR_RXBUF, 0); chk("rxbuf", rd[8:0] & m, exp_rx(i == 2, b) & m);
      if (i < 2)
        chk("acks", (n_ack - a) * 2 + n_nack - q, (i == 0) ? 2 : 1);
    end
    bus(1, ADDR_BUS, 32'h2);
    bus(1, ADDR_TXBUF, 32'h1ff);
    wait_done;
    chk("hold", scl_oe, 1);
    bus(1, ADDR_BUS, 0);
    repeat (2) @(posedge clk);
    chk("free", scl_oe, 0);
    bus(1, ADDR_BUS, 32'h4);
    repeat (2) @(posedge clk);
    chk("force", scl_oe, 1);
    bus(1, ADDR_BUS, 0);
    repeat (2) @(posedge clk);
    chk("unforce", scl_oe, 0);
    test_done;
  end
endmodule
`default_nettype wire
